// >>> self_test_pkg.sv
package self_test_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_FREQ_HZ     = 20000000;
	localparam int unsigned LAMP_TIME_MS    = 100;
	localparam int unsigned FLASH_TIME_MS   = 200;
	localparam int unsigned BLINK_TIME_MS   = 250;
	localparam int unsigned LAMP_CYCLES_DEF  = LAMP_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int unsigned FLASH_CYCLES_DEF = FLASH_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int unsigned BLINK_CYCLES_DEF = BLINK_TIME_MS * (CLK_FREQ_HZ / 1000);

	// ==========================================================
	// Test numbers (octal values held in four bits)
	localparam logic [3:0] TEST_FIRST      = 4'hf;
	localparam logic [3:0] TEST_LAST       = 4'h3;
	localparam logic [3:0] TEST_HANG_LOW   = 4'hd;
	localparam logic [3:0] TEST_PHASE_TUNE = 4'h2;
	localparam logic [3:0] TEST_SEEKS      = 4'h1;
	localparam logic [3:0] TEST_ALL        = 4'h0;
	localparam logic [3:0] DISP_NOT_READY  = 4'h8;
	localparam logic [3:0] DISP_ALL_ON     = 4'hf;
	localparam logic [3:0] DISP_BLANK      = 4'h0;
	localparam logic [15:0] READY_MASK_DEF = 16'h0018;

	// ==========================================================
	// Register map
	localparam logic [7:0] REG_COMMAND = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_OUTCOME = 8'h08;
	localparam int unsigned CMD_BEGIN_BIT = 0;
	localparam int unsigned CMD_END_BIT   = 1;
	localparam int unsigned CMD_IDLE3_BIT = 2;
	localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

	// ==========================================================
	// Types
	typedef struct packed {
		logic       valid;
		logic [3:0] number;
	} test_req_type;

	typedef struct packed {
		logic       done;
		logic       pass;
		logic [3:0] section;
	} test_rsp_type;

	typedef enum logic [1:0] {
		CTL_IDLE2,
		CTL_IDLE3,
		CTL_FIRMWARE,
		CTL_TESTING
	} ctl_type;

endpackage

// >>> self_test_sequencer.sv
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Run tests descending from 17 to 3.
// - First test lights all; full pass blanks.
// - Start by power, run, command, idle button.
// - Button ignored while corner lamp lit.
// - Not ready in operating mode: flash 10.
// - Resume sequence once drive becomes ready.
// - Lamp test flash at every run start.
// - Operating mode failure holds test number.
// - Failure lamps steady; otherwise all dark.
// - Failure in 17..15 hangs controller.
// - Other operating mode outcomes hand over to firmware.
// - Leaves drive lamps, run, ready untouched.
// - Service loops selected test; zero loops all.
// - Single test failure shows section number.
// - Whole program failure shows test number.
// - Service pass flashes the test number.
// - Held start restarts after failure, service mode; a test 17 failure hangs instead.
// - Thirteen tests, two adjustments, fifteen sections.
// - End command enters idle state 2.
// - Normal drive operation only in operating position.
// - Selections 2 and 1 run adjustments, flashing.
// - Hang left only by reset or run.
module self_test_sequencer
	import self_test_pkg::*;
#(
	parameter int unsigned  LAMP_CYCLES  = LAMP_CYCLES_DEF,
	parameter int unsigned  FLASH_CYCLES = FLASH_CYCLES_DEF,
	parameter int unsigned  BLINK_CYCLES = BLINK_CYCLES_DEF,
	parameter logic [15:0]  READY_MASK   = READY_MASK_DEF
) (
	// Clock and reset
	input  wire logic                        MCLK_I,
	input  wire logic                        RST_N_I,
	// APB slave
	input  wire logic                        PSEL_I,
	input  wire logic                        PENABLE_I,
	input  wire logic                        PWRITE_I,
	input  wire logic [7:0]                  PADDR_I,
	input  wire logic [31:0]                 PWDATA_I,
	output logic [31:0]                      PRDATA_O,
	output logic                             PREADY_O,
	output logic                             PSLVERR_O,
	// Panel and drive pins
	input  wire logic                        OPERATING_SERVICE_SELECT_I,
	input  wire logic [3:0]                  TEST_SELECT_I,
	input  wire logic                        START_BUTTON_I,
	input  wire logic                        RUN_CONTROL_I,
	input  wire logic                        DRIVE_READY_I,
	// Test engine
	output self_test_pkg::test_req_type      TEST_REQ_O,
	input  wire self_test_pkg::test_rsp_type TEST_RSP_I,
	// Indicators and status
	output logic [3:0]                       RESULT_DISPLAY_O,
	output logic                             FAIL_LAMP_O,
	output logic                             FRONT_FAIL_O,
	output logic                             UNIT_LAMP_O,
	output logic                             FIRMWARE_ACTIVE_O,
	output logic                             DRIVE_ENABLE_O
);

	import self_test_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_LAMP,
		ST_ISSUE,
		ST_WAIT,
		ST_READY_WAIT,
		ST_PASS_FLASH,
		ST_HALT,
		ST_HANG
	} state_type;

	// ==========================================================
	// Pin synchronisers
	logic [7:0] pin_meta_q;
	logic [7:0] pin_sync_q;
	logic       start_prev_q;
	logic       run_prev_q;

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pin_meta_q <= 8'h00;
			pin_sync_q <= 8'h00;
		end else begin
			pin_meta_q <= {DRIVE_READY_I, RUN_CONTROL_I, START_BUTTON_I,
				OPERATING_SERVICE_SELECT_I, TEST_SELECT_I};
			pin_sync_q <= pin_meta_q;
		end
	end

	logic [3:0] test_sel;
	logic       op_mode;
	logic       start_held;
	logic       run_on;
	logic       drive_ready;
	assign test_sel    = pin_sync_q[3:0];
	assign op_mode     = pin_sync_q[4];
	assign start_held  = pin_sync_q[5];
	assign run_on      = pin_sync_q[6];
	// Drive ready is only observed, never gated by a failure
	assign drive_ready = pin_sync_q[7];

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			start_prev_q <= 1'b0;
			run_prev_q   <= 1'b0;
		end else begin
			start_prev_q <= start_held;
			run_prev_q   <= run_on;
		end
	end

	logic start_rise;
	logic run_rise;
	assign start_rise = start_held && !start_prev_q;
	assign run_rise   = run_on && !run_prev_q;

	// ==========================================================
	// Sequencer state
	state_type  state_q;
	ctl_type    ctl_q;
	logic [3:0] cur_test_q;
	logic       single_q;
	logic       service_q;
	logic       fail_q;
	logic [3:0] fail_test_q;
	logic [3:0] fail_disp_q;
	logic [3:0] fail_section_q;
	logic [31:0] count_q;
	logic [31:0] blink_cnt_q;
	logic       blink_q;
	logic       req_q;

	logic cmd_begin;
	logic cmd_end;
	logic cmd_idle3;
	logic lamp_dark;
	logic hung;
	logic start_run;

	assign hung = (state_q == ST_HANG);
	// Corner lamp dark only in idle 2, idle 3 or while testing
	assign lamp_dark = (ctl_q == CTL_IDLE2) || (ctl_q == CTL_IDLE3) ||
		(ctl_q == CTL_TESTING);
	// Run toggle restarts even from a hang; all else is ignored there
	assign start_run = run_rise ||
		(!hung && cmd_begin && op_mode) ||
		(!hung && start_rise && lamp_dark &&
			(state_q == ST_IDLE || state_q == ST_HALT));

	logic timer_done;
	logic needs_ready;
	assign needs_ready = READY_MASK[cur_test_q];

	always_comb begin
		timer_done = 1'b0;
		case (state_q)
			ST_LAMP:       timer_done = (count_q >= LAMP_CYCLES - 1);
			ST_PASS_FLASH: timer_done = (count_q >= FLASH_CYCLES - 1);
			default:       timer_done = 1'b0;
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			count_q <= 32'h0000_0000;
		end else if (state_q == ST_LAMP || state_q == ST_PASS_FLASH) begin
			count_q <= count_q + 32'h0000_0001;
		end else begin
			count_q <= 32'h0000_0000;
		end
	end

	// Free-running blink phase for flashing displays
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			blink_cnt_q <= 32'h0000_0000;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q >= BLINK_CYCLES - 1) begin
			blink_cnt_q <= 32'h0000_0000;
			blink_q     <= !blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
		end
	end

	// Main sequence; power-on reset itself starts a run
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_q    <= ST_LAMP;
			cur_test_q <= TEST_FIRST;
			single_q   <= 1'b0;
			service_q  <= 1'b0;
			req_q      <= 1'b0;
		end else begin
			req_q <= 1'b0;
			if (start_run) begin
				state_q <= ST_LAMP;
			end else begin
				case (state_q)
					ST_IDLE, ST_HALT: begin
						state_q <= state_q;
					end
					ST_LAMP: begin
						if (timer_done) begin
							service_q <= !op_mode;
							// Nonzero selection loops one test
							single_q <= !op_mode && (test_sel != TEST_ALL);
							cur_test_q <= (!op_mode && test_sel != TEST_ALL) ?
								test_sel : TEST_FIRST;
							state_q <= ST_ISSUE;
						end
					end
					ST_ISSUE: begin
						if (!service_q && needs_ready && !drive_ready) begin
							state_q <= ST_READY_WAIT;
						end else begin
							req_q   <= 1'b1;
							state_q <= ST_WAIT;
						end
					end
					ST_READY_WAIT: begin
						if (drive_ready) begin
							state_q <= ST_ISSUE;
						end
					end
					ST_WAIT: begin
						if (TEST_RSP_I.done && TEST_RSP_I.pass) begin
							if (service_q) begin
								state_q <= ST_PASS_FLASH;
							end else if (cur_test_q == TEST_LAST) begin
								state_q <= ST_IDLE;
							end else begin
								cur_test_q <= cur_test_q - 4'h1;
								state_q    <= ST_ISSUE;
							end
						end else if (TEST_RSP_I.done) begin
							if (service_q && start_held && cur_test_q != TEST_FIRST) begin
								state_q <= ST_LAMP;
							end else if (cur_test_q >= TEST_HANG_LOW) begin
								state_q <= ST_HANG;
							end else if (service_q) begin
								state_q <= ST_HALT;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_PASS_FLASH: begin
						if (timer_done) begin
							state_q <= ST_ISSUE;
							if (!single_q) begin
								// Whole program wraps to keep looping
								cur_test_q <= (cur_test_q == TEST_LAST) ?
									TEST_FIRST : cur_test_q - 4'h1;
							end
						end
					end
					ST_HANG: begin
						state_q <= ST_HANG;
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Failure record; flag and display cleared only when a new run begins, test and section kept
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			fail_q         <= 1'b0;
			fail_test_q    <= DISP_BLANK;
			fail_section_q <= DISP_BLANK;
			fail_disp_q    <= DISP_BLANK;
		end else if (state_q == ST_WAIT && TEST_RSP_I.done && !TEST_RSP_I.pass) begin
			fail_q         <= 1'b1;
			fail_test_q    <= cur_test_q;
			fail_section_q <= TEST_RSP_I.section;
			fail_disp_q    <= single_q ? TEST_RSP_I.section : cur_test_q;
		end else if (state_q == ST_LAMP) begin
			fail_q      <= 1'b0;
			fail_disp_q <= DISP_BLANK;
		end
	end

	// ==========================================================
	// Controller state as seen by the host
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctl_q <= CTL_TESTING;
		end else if (start_run || state_q == ST_LAMP) begin
			ctl_q <= CTL_TESTING;
		end else if (state_q == ST_WAIT && TEST_RSP_I.done && !service_q &&
			(TEST_RSP_I.pass ? cur_test_q == TEST_LAST : cur_test_q < TEST_HANG_LOW)) begin
			ctl_q <= CTL_FIRMWARE;
		end else if (!hung && ctl_q != CTL_TESTING && cmd_end) begin
			ctl_q <= CTL_IDLE2;
		end else if (!hung && ctl_q != CTL_TESTING && cmd_idle3) begin
			ctl_q <= CTL_IDLE3;
		end
	end

	// ==========================================================
	// Indicators, all registered
	logic [3:0] disp_d;
	logic       lamps_d;

	always_comb begin
		disp_d  = DISP_BLANK;
		lamps_d = fail_q;
		case (state_q)
			ST_LAMP: begin
				disp_d  = DISP_ALL_ON;
				lamps_d = 1'b1;
			end
			ST_ISSUE, ST_WAIT: begin
				disp_d = (cur_test_q == TEST_FIRST) ? DISP_ALL_ON : DISP_BLANK;
			end
			ST_READY_WAIT: begin
				disp_d = blink_q ? DISP_NOT_READY : DISP_BLANK;
			end
			ST_PASS_FLASH: begin
				disp_d = cur_test_q;
			end
			ST_HALT, ST_HANG, ST_IDLE: begin
				disp_d = fail_q ? fail_disp_q : DISP_BLANK;
			end
			default: begin
				disp_d = DISP_BLANK;
			end
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			RESULT_DISPLAY_O  <= DISP_BLANK;
			FAIL_LAMP_O       <= 1'b0;
			FRONT_FAIL_O      <= 1'b0;
			UNIT_LAMP_O       <= 1'b0;
			FIRMWARE_ACTIVE_O <= 1'b0;
			DRIVE_ENABLE_O    <= 1'b0;
		end else begin
			RESULT_DISPLAY_O  <= disp_d;
			FAIL_LAMP_O       <= lamps_d;
			FRONT_FAIL_O      <= lamps_d;
			UNIT_LAMP_O       <= !lamp_dark;
			FIRMWARE_ACTIVE_O <= (ctl_q != CTL_TESTING) && op_mode;
			DRIVE_ENABLE_O    <= op_mode;
		end
	end

	assign TEST_REQ_O = '{valid: req_q, number: cur_test_q};

	// ==========================================================
	// APB slave, zero wait states
	logic access;
	logic wr_cmd;
	logic addr_ok;
	assign access  = PSEL_I && PENABLE_I;
	assign addr_ok = (PADDR_I == REG_COMMAND) || (PADDR_I == REG_STATUS) ||
		(PADDR_I == REG_OUTCOME);
	assign wr_cmd  = access && PWRITE_I && (PADDR_I == REG_COMMAND);
	// Host commands reach logic only in operating mode; begin also works while testing
	assign cmd_begin = wr_cmd && PWDATA_I[CMD_BEGIN_BIT];
	assign cmd_end   = wr_cmd && PWDATA_I[CMD_END_BIT] && op_mode;
	assign cmd_idle3 = wr_cmd && PWDATA_I[CMD_IDLE3_BIT] && op_mode;

	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = access && !addr_ok;

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PRDATA_O <= RDATA_RESET;
		end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			case (PADDR_I)
				REG_STATUS: begin
					PRDATA_O <= {12'h000, 2'(state_q == ST_HALT), 2'(ctl_q), 4'(state_q),
						3'h0, hung, 4'h0, RESULT_DISPLAY_O};
				end
				REG_OUTCOME: begin
					PRDATA_O <= {19'h00000, fail_q, fail_section_q, fail_test_q,
						fail_disp_q};
				end
				default: begin
					PRDATA_O <= RDATA_RESET;
				end
			endcase
		end
	end

endmodule

// >>> test_engine_model.sv
`timescale 1ns/1ps
module test_engine_model (
	// Clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	// Sequencer side
	input  wire self_test_pkg::test_req_type req_i,
	output self_test_pkg::test_rsp_type      rsp_o,
	// Scenario control
	input  wire logic [3:0]                  fail_num_i,
	input  wire logic [3:0]                  fail_sect_i,
	input  wire logic [3:0]                  lat_i
);
	import self_test_pkg::*;
	// ==========================================================
	// Answer each request after lat_i idle cycles
	logic       busy_q;
	logic [3:0] cnt_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_q <= 1'b0;
			cnt_q  <= 4'h0;
			rsp_o  <= '0;
		end else begin
			rsp_o.done    <= 1'b0;
			// Stale fields toggle, so a late sampler never reads a lucky value
			rsp_o.pass    <= ~rsp_o.pass;
			rsp_o.section <= ~rsp_o.section;
			if (req_i.valid) begin
				busy_q <= 1'b1;
				cnt_q  <= lat_i;
			end else if (busy_q && cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end else if (busy_q) begin
				busy_q        <= 1'b0;
				rsp_o.done    <= 1'b1;
				rsp_o.pass    <= req_i.number != fail_num_i;
				rsp_o.section <= fail_sect_i;
			end
		end
	end
endmodule

// >>> self_test_assertions.sv
`timescale 1ns/1ps
module self_test_checker #(
	parameter logic [15:0] READY_MASK = 16'h0018
) (
	// Clock and reset
	input wire logic                        MCLK_I,
	input wire logic                        RST_N_I,
	// Watched pins
	input wire logic                        OPERATING_SERVICE_SELECT_I,
	input wire logic                        DRIVE_READY_I,
	input wire self_test_pkg::test_req_type TEST_REQ_O,
	input wire self_test_pkg::test_rsp_type TEST_RSP_I,
	input wire logic [3:0]                  RESULT_DISPLAY_O,
	input wire logic                        FAIL_LAMP_O,
	input wire logic                        FRONT_FAIL_O,
	input wire logic                        UNIT_LAMP_O,
	input wire logic                        DRIVE_ENABLE_O
);
	import self_test_pkg::*;
	// ==========================================================
	// Number of the last answered test
	logic [3:0] done_num_q;
	logic       opm;
	assign opm = OPERATING_SERVICE_SELECT_I;
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			done_num_q <= 4'h0;
		else if (TEST_RSP_I.done)
			done_num_q <= TEST_REQ_O.number;
	end
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	// ==========================================================
	// Properties
	property p_descend;
		TEST_RSP_I.done && TEST_RSP_I.pass && opm && TEST_REQ_O.number > 4'h5 |->
			##[1:3] (TEST_REQ_O.valid && TEST_REQ_O.number == done_num_q - 4'h1);
	endproperty
	a_descend: assert property (p_descend) else $error("test order not descending");
	property p_pass_blank;
		TEST_RSP_I.done && TEST_RSP_I.pass && opm && TEST_REQ_O.number == 4'h3 |->
			##[1:4] (RESULT_DISPLAY_O == 4'h0 && !FAIL_LAMP_O);
	endproperty
	a_pass_blank: assert property (p_pass_blank) else $error("display not blank");
	property p_lamp_dark;
		TEST_REQ_O.valid |-> !UNIT_LAMP_O;
	endproperty
	a_lamp_dark: assert property (p_lamp_dark) else $error("corner lamp lit in test");
	property p_wait_ready;
		(opm && !DRIVE_READY_I) [*4] |-> !(TEST_REQ_O.valid && READY_MASK[TEST_REQ_O.number]);
	endproperty
	a_wait_ready: assert property (p_wait_ready) else $error("ran test without ready");
	property p_fail_lit;
		TEST_RSP_I.done && !TEST_RSP_I.pass |-> ##[1:4] FAIL_LAMP_O;
	endproperty
	a_fail_lit: assert property (p_fail_lit) else $error("fail lamp dark on failure");
	property p_twin;
		FAIL_LAMP_O == FRONT_FAIL_O;
	endproperty
	a_twin: assert property (p_twin) else $error("fail indicators differ");
	property p_hang;
		TEST_RSP_I.done && !TEST_RSP_I.pass && opm && TEST_REQ_O.number >= 4'hd |->
			##[1:4] RESULT_DISPLAY_O == done_num_q;
	endproperty
	a_hang: assert property (p_hang) else $error("hang shows wrong number");
	property p_service_off;
		(!opm) [*4] |-> !DRIVE_ENABLE_O;
	endproperty
	a_service_off: assert property (p_service_off) else $error("drive on in service");
	c_pass: cover property (TEST_RSP_I.done && TEST_RSP_I.pass && TEST_REQ_O.number == 4'h3);
	c_hang: cover property (TEST_RSP_I.done && !TEST_RSP_I.pass && TEST_REQ_O.number == 4'hf);
	c_flash: cover property (!opm && RESULT_DISPLAY_O == 4'h9);
endmodule
bind self_test_sequencer self_test_checker #(.READY_MASK(READY_MASK)) u_chk (
	.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .DRIVE_READY_I(DRIVE_READY_I),
	.OPERATING_SERVICE_SELECT_I(OPERATING_SERVICE_SELECT_I), .TEST_REQ_O(TEST_REQ_O),
	.TEST_RSP_I(TEST_RSP_I), .RESULT_DISPLAY_O(RESULT_DISPLAY_O), .FAIL_LAMP_O(FAIL_LAMP_O),
	.FRONT_FAIL_O(FRONT_FAIL_O), .UNIT_LAMP_O(UNIT_LAMP_O), .DRIVE_ENABLE_O(DRIVE_ENABLE_O));

// >>> tb_controller_self_test_sequencer.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; \
	$display("mismatch %s exp %h got %h", n, e, a); end end
module tb_controller_self_test_sequencer;
	import self_test_pkg::*;
	// ==========================================================
	// Signals
	logic         clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
	logic         opsel, start, run, dready, fail_lamp, front_fail, unit_lamp, fw_act, drv_en;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rdata;
	logic [3:0]   tsel, disp, fail_num, fail_sect, lat;
	test_req_type req;
	test_rsp_type rsp;
	int           fails, comparisons, r0;
	int           reqs = 0;
	// Short counts keep the run brief
	self_test_sequencer #(.LAMP_CYCLES(8), .FLASH_CYCLES(6), .BLINK_CYCLES(4)) uut (
		.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .OPERATING_SERVICE_SELECT_I(opsel), .TEST_SELECT_I(tsel),
		.START_BUTTON_I(start), .RUN_CONTROL_I(run), .DRIVE_READY_I(dready), .TEST_REQ_O(req),
		.TEST_RSP_I(rsp), .RESULT_DISPLAY_O(disp), .FAIL_LAMP_O(fail_lamp),
		.FRONT_FAIL_O(front_fail), .UNIT_LAMP_O(unit_lamp), .FIRMWARE_ACTIVE_O(fw_act),
		.DRIVE_ENABLE_O(drv_en));
	test_engine_model engine (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .rsp_o(rsp),
		.fail_num_i(fail_num), .fail_sect_i(fail_sect), .lat_i(lat));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (req.valid === 1'b1) reqs <= reqs + 1;
	// ==========================================================
	// Shared tasks
	task end_sim();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int i;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rdata = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'b00;
		if (i == 50) begin
			fails++;
			$display("mismatch apb ready exp 1 got timeout");
			end_sim();
		end
	endtask
	// Wait kinds: 0 display value, 1 request of a test, 2 firmware active
	task wt(input int k, input logic [3:0] v);
		int i;
		for (i = 0; i < 4000; i++) begin
			@(negedge clk);
			if (k == 0 ? disp === v : k == 1 ? req.valid === 1'b1 && req.number === v
				: fw_act === 1'b1) break;
		end
		comparisons++;
		if (i == 4000) begin
			fails++;
			$display("mismatch wait %0d exp %h got timeout", k, v);
			end_sim();
		end
	endtask
	task pulse(input logic s);
		@(posedge clk);
		if (s) start <= 1'b1; else run <= 1'b1;
		repeat (4) @(posedge clk);
		{start, run} <= 2'b00;
	endtask
	// ==========================================================
	// Scenarios
	task t_power();
		`CHK("lamp test display", DISP_ALL_ON, disp)
		`CHK("lamp test front", 1'b1, front_fail)
		wt(1, 4'hf);
		wt(0, DISP_NOT_READY);
		@(posedge clk);
		dready <= 1'b1;
		wt(2, 4'h0);
		`CHK("pass display", DISP_BLANK, disp)
		`CHK("pass fail lamp", 1'b0, fail_lamp)
		`CHK("corner lamp", 1'b1, unit_lamp)
		apb(1'b0, REG_OUTCOME, 32'h0);
		`CHK("outcome flag", 1'b0, rdata[12])
		apb(1'b0, 8'h3c, 32'h0);
		`CHK("unmapped error", 1'b1, rerr)
		$display("scenario power done");
	endtask
	task t_fail_op();
		fail_num <= 4'ha;
		apb(1'b1, REG_COMMAND, 32'h1 << CMD_BEGIN_BIT);
		wt(0, DISP_ALL_ON);
		wt(2, 4'h0);
		`CHK("failed number", 4'ha, disp)
		`CHK("front fail", 1'b1, front_fail)
		`CHK("drive on after failure", 1'b1, drv_en)
		apb(1'b0, REG_OUTCOME, 32'h0);
		`CHK("outcome test", 4'ha, rdata[7:4])
		$display("scenario operating failure done");
	endtask
	task t_button();
		fail_num <= 4'h0;
		r0 = reqs;
		pulse(1'b1);
		repeat (20) @(negedge clk);
		`CHK("start ignored", r0, reqs)
		apb(1'b1, REG_COMMAND, 32'h1 << CMD_END_BIT);
		repeat (4) @(negedge clk);
		`CHK("corner lamp dark", 1'b0, unit_lamp)
		pulse(1'b1);
		wt(0, DISP_ALL_ON);
		wt(2, 4'h0);
		`CHK("clean pass", DISP_BLANK, disp)
		apb(1'b1, REG_COMMAND, 32'h1 << CMD_IDLE3_BIT);
		apb(1'b0, REG_STATUS, 32'h0);
		@(negedge clk);
		`CHK("idle 3 state", 2'h1, rdata[17:16])
		`CHK("corner lamp idle 3", 1'b0, unit_lamp)
		$display("scenario start button done");
	endtask
	task t_service();
		apb(1'b1, REG_COMMAND, 32'h1 << CMD_END_BIT);
		{opsel, tsel, lat} <= {1'b0, 4'h9, 4'hc};
		repeat (4) @(negedge clk);
		`CHK("drive off in service", 1'b0, drv_en)
		pulse(1'b1);
		wt(1, 4'h9);
		wt(0, 4'h9);
		wt(1, 4'h9);
		{fail_num, fail_sect} <= {4'h9, 4'h5};
		wt(0, 4'h5);
		repeat (10) @(negedge clk);
		`CHK("section held", 4'h5, disp)
		`CHK("service fail lamp", 1'b1, fail_lamp)
		@(posedge clk);
		{tsel, fail_num} <= {4'h0, 4'hb};
		pulse(1'b1);
		wt(1, 4'hf);
		wt(0, 4'hc);
		wt(0, 4'hb);
		repeat (10) @(negedge clk);
		`CHK("failed test held", 4'hb, disp)
		$display("scenario service loop done");
	endtask
	task t_modes();
		@(posedge clk);
		{tsel, fail_num} <= {TEST_PHASE_TUNE, 4'h0};
		pulse(1'b1);
		wt(0, TEST_PHASE_TUNE);
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK("service loops in test", 2'h3, rdata[17:16])
		// Held start turns the next failure into a restart
		{start, fail_num} <= {1'b1, TEST_PHASE_TUNE};
		wt(0, DISP_ALL_ON);
		wt(1, TEST_PHASE_TUNE);
		@(posedge clk);
		start <= 1'b0;
		wt(0, 4'h5);
		$display("scenario held start done");
	endtask
	task t_hang();
		@(posedge clk);
		{opsel, lat, fail_num} <= {1'b1, 4'h0, 4'hf};
		pulse(1'b0);
		wt(1, 4'hf);
		repeat (10) @(negedge clk);
		r0 = reqs;
		apb(1'b1, REG_COMMAND, 32'h1 << CMD_BEGIN_BIT);
		pulse(1'b1);
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK("hung flag", 1'b1, rdata[8])
		repeat (20) @(negedge clk);
		`CHK("hung ignores requests", r0, reqs)
		`CHK("hung display", 4'hf, disp)
		`CHK("drive on in operating", 1'b1, drv_en)
		fail_num <= 4'h0;
		pulse(1'b0);
		wt(1, 4'hf);
		$display("scenario hang done");
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, tsel, fail_num, fail_sect} = '0;
		{start, run, dready, rst_n, fails, comparisons} = '0;
		opsel = 1'b1;
		lat = 4'h1;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge clk);
		t_power();
		t_fail_op();
		t_button();
		t_service();
		t_modes();
		t_hang();
		end_sim();
	end
endmodule
